/* verilog/wex_pkg.sv */
/*
 * Constants and carrier types for the waveform fault and dead-time register block.
 * Assumes a 32-bit APB master and a timer/counter that shares the peripheral clock.
 */
package wex_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [3:0] IDX_CONTROL = 4'h0;
    localparam logic [3:0] IDX_EVENT_MASK = 4'h2;
    localparam logic [3:0] IDX_FAULT_CONFIG = 4'h3;
    localparam logic [3:0] IDX_STATUS = 4'h4;
    localparam logic [3:0] IDX_DT_DUAL = 4'h6;
    localparam logic [3:0] IDX_DT_DUAL_BUF = 4'h7;
    localparam logic [3:0] IDX_DT_LOW = 4'h8;
    localparam logic [3:0] IDX_DT_HIGH = 4'h9;
    localparam logic [3:0] IDX_DT_LOW_BUF = 4'hA;
    localparam logic [3:0] IDX_DT_HIGH_BUF = 4'hB;
    localparam logic [3:0] IDX_OVERRIDE = 4'hC;

    // Field positions and the control write width
    localparam int CTRL_CWCM_BIT = 4;
    localparam int CTRL_WRITE_MASK_WIDTH = 6;
    localparam int CFG_DBG_DIS_BIT = 4;
    localparam int CFG_MODE_BIT = 2;
    localparam int STAT_FAULT_BIT = 2;
    localparam int STAT_HS_VALID_BIT = 1;
    localparam int STAT_LS_VALID_BIT = 0;

    // Fault action codes
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_CLEAR_DIR = 2'h3;

    // Restart modes
    localparam logic MODE_LATCHED = 1'b0;
    localparam logic MODE_CYCLE = 1'b1;

    // Reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [31:0] RESET_WORD = 32'h00000000;

    localparam int CHANNELS = 4;

    typedef struct packed {
        logic [7:0] control;
        logic [7:0] event_mask;
        logic debug_break_fault_disable;
        logic fault_restart_mode;
        logic [1:0] fault_action;
        logic fault_flag;
        logic fault_state;
        logic high_side_buffer_valid;
        logic low_side_buffer_valid;
        logic [7:0] deadtime_low_side;
        logic [7:0] deadtime_high_side;
        logic [7:0] deadtime_low_side_buffer;
        logic [7:0] deadtime_high_side_buffer;
        logic [7:0] pin_override_enable;
        logic [CHANNELS-1:0] wave_prev;
        logic [CHANNELS-1:0][7:0] dt_count;
        logic [7:0] dt_out;
        logic [7:0] dir_out;
        logic [7:0] pin_out;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } state_t;

endpackage

/* verilog/waveform_fault_deadtime_regs.sv */
/*
 * Fault protection, dead-time value registers with double buffers, pin override
 * and a small dead-time generator, reached as an APB slave.
 * Assumes the timer, event channels, debug break and port signals are on clk.
 */
// Implementation choice: register access over APB.
`timescale 1ns/1ns

module waveform_fault_deadtime_regs #(
    parameter int EVENT_CHANNELS = 8
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic timer_update,
    input wire logic lock_update,
    input wire logic [EVENT_CHANNELS-1:0] event_in,
    input wire logic debug_break,
    input wire logic [wex_pkg::CHANNELS-1:0] timer_wave,
    input wire logic [7:0] port_dir,
    input wire logic [7:0] port_out,
    output logic [7:0] deadtime_out,
    output logic [7:0] dir_out,
    output logic [7:0] pin_out,
    output logic fault_flag,
    output logic fault_state
);

    ////////////////////////////////////////////////////////////////////////////////
    // State

    wex_pkg::state_t state_reg;
    wex_pkg::state_t state_next;

    logic [3:0] idx;
    logic addr_ok;
    logic setup_phase;
    logic wr_en;
    logic fault_source;
    logic fault_event;
    logic update_ok;
    logic [7:0] wdata;
    logic [7:0] dir_mask;
    logic [7:0] rd_byte;
    logic [7:0] dt_next;
    logic [7:0] pin_next;
    logic [wex_pkg::CHANNELS-1:0] wave_sel;
    logic [wex_pkg::CHANNELS-1:0][7:0] count_next;

    assign idx = paddr[5:2];
    assign wdata = pwdata[7:0];

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode

    always_comb
    begin
        unique case (idx)
            wex_pkg::IDX_CONTROL,
            wex_pkg::IDX_EVENT_MASK,
            wex_pkg::IDX_FAULT_CONFIG,
            wex_pkg::IDX_STATUS,
            wex_pkg::IDX_DT_DUAL,
            wex_pkg::IDX_DT_DUAL_BUF,
            wex_pkg::IDX_DT_LOW,
            wex_pkg::IDX_DT_HIGH,
            wex_pkg::IDX_DT_LOW_BUF,
            wex_pkg::IDX_DT_HIGH_BUF,
            wex_pkg::IDX_OVERRIDE:
                addr_ok = (paddr[1:0] == 2'h0) && (paddr[7:6] == 2'h0);
            default:
                addr_ok = 1'b0;
        endcase
    end

    assign setup_phase = psel && !penable;
    // Write lands at the edge where pready is sampled high
    assign wr_en = psel && penable && state_reg.pready && pwrite && addr_ok && pstrb[0];

    ////////////////////////////////////////////////////////////////////////////////
    // Fault detection

    // Masked channels ORed, debug break joins unless disabled
    assign fault_source = (|(event_in & state_reg.event_mask))
        || (debug_break && !state_reg.debug_break_fault_disable);
    assign fault_event = fault_source && (state_reg.fault_action != wex_pkg::ACT_NONE);
    // Buffer copies wait for UPDATE and stay off while locked
    assign update_ok = timer_update && !lock_update;

    ////////////////////////////////////////////////////////////////////////////////
    // Read mux

    always_comb
    begin
        rd_byte = wex_pkg::RESET_BYTE;
        unique case (idx)
            wex_pkg::IDX_CONTROL:
                rd_byte = state_reg.control;
            wex_pkg::IDX_EVENT_MASK:
                rd_byte = state_reg.event_mask;
            wex_pkg::IDX_FAULT_CONFIG:
            begin
                rd_byte[wex_pkg::CFG_DBG_DIS_BIT] = state_reg.debug_break_fault_disable;
                rd_byte[wex_pkg::CFG_MODE_BIT] = state_reg.fault_restart_mode;
                rd_byte[1:0] = state_reg.fault_action;
            end
            wex_pkg::IDX_STATUS:
            begin
                rd_byte[wex_pkg::STAT_FAULT_BIT] = state_reg.fault_flag;
                rd_byte[wex_pkg::STAT_HS_VALID_BIT] = state_reg.high_side_buffer_valid;
                rd_byte[wex_pkg::STAT_LS_VALID_BIT] = state_reg.low_side_buffer_valid;
            end
            wex_pkg::IDX_DT_DUAL,
            wex_pkg::IDX_DT_LOW:
                rd_byte = state_reg.deadtime_low_side;
            wex_pkg::IDX_DT_DUAL_BUF,
            wex_pkg::IDX_DT_LOW_BUF:
                rd_byte = state_reg.deadtime_low_side_buffer;
            wex_pkg::IDX_DT_HIGH:
                rd_byte = state_reg.deadtime_high_side;
            wex_pkg::IDX_DT_HIGH_BUF:
                rd_byte = state_reg.deadtime_high_side_buffer;
            wex_pkg::IDX_OVERRIDE:
                rd_byte = state_reg.pin_override_enable;
            default:
                rd_byte = wex_pkg::RESET_BYTE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Dead-time generator per channel

    for (genvar g = 0; g < wex_pkg::CHANNELS; g++)
    begin : g_dt
        logic wave_g;
        logic [7:0] count_g;
        logic low_g;
        logic high_g;

        // Common mode feeds channel A to every generator
        assign wave_g = state_reg.control[wex_pkg::CTRL_CWCM_BIT] ? timer_wave[0] : timer_wave[g];

        always_comb
        begin
            // Edges reload, otherwise count down to zero
            if (wave_g && !state_reg.wave_prev[g])
            begin
                count_g = state_reg.deadtime_low_side;
            end
            else if (!wave_g && state_reg.wave_prev[g])
            begin
                count_g = state_reg.deadtime_high_side;
            end
            else if (state_reg.dt_count[g] != 8'h00)
            begin
                count_g = state_reg.dt_count[g] - 8'h01;
            end
            else
            begin
                count_g = 8'h00;
            end
            // With control[g] set a nonzero count holds both sides off; else the low side is timer_wave[g]
            if (state_reg.control[g])
            begin
                low_g = !wave_g && (count_g == 8'h00);
                high_g = wave_g && (count_g == 8'h00);
            end
            else
            begin
                low_g = timer_wave[g];
                high_g = 1'b0;
            end
        end

        assign wave_sel[g] = wave_g;
        assign count_next[g] = count_g;
        assign dt_next[2*g] = low_g;
        assign dt_next[2*g+1] = high_g;
        assign dir_mask[2*g] = state_reg.control[g];
        assign dir_mask[2*g+1] = state_reg.control[g];
    end

    // Override swaps the output value, direction untouched
    for (genvar p = 0; p < 8; p++)
    begin : g_pin
        assign pin_next[p] = state_reg.pin_override_enable[p] ? dt_next[p]
            : port_out[p];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        state_next = state_reg;

        // APB answer: ready one cycle after setup, data captured at setup
        state_next.pready = setup_phase;
        state_next.pslverr = setup_phase && !addr_ok;
        if (setup_phase)
        begin
            // Refused addresses read as zero
            state_next.prdata = (pwrite || !addr_ok) ? wex_pkg::RESET_WORD
                : {24'h000000, rd_byte};
        end

        // Buffer transfer at UPDATE, valid bits consumed
        if (update_ok && state_reg.low_side_buffer_valid)
        begin
            state_next.deadtime_low_side = state_reg.deadtime_low_side_buffer;
            state_next.low_side_buffer_valid = 1'b0;
        end
        if (update_ok && state_reg.high_side_buffer_valid)
        begin
            state_next.deadtime_high_side = state_reg.deadtime_high_side_buffer;
            state_next.high_side_buffer_valid = 1'b0;
        end

        // Register writes; a direct write overrides a same-cycle transfer
        if (wr_en)
        begin
            unique case (idx)
                wex_pkg::IDX_CONTROL:
                    state_next.control = {2'h0, wdata[wex_pkg::CTRL_WRITE_MASK_WIDTH-1:0]};
                wex_pkg::IDX_EVENT_MASK:
                    state_next.event_mask = wdata;
                wex_pkg::IDX_FAULT_CONFIG:
                begin
                    state_next.debug_break_fault_disable = wdata[wex_pkg::CFG_DBG_DIS_BIT];
                    state_next.fault_restart_mode = wdata[wex_pkg::CFG_MODE_BIT];
                    state_next.fault_action = wdata[1:0];
                end
                wex_pkg::IDX_STATUS:
                begin
                    if (wdata[wex_pkg::STAT_FAULT_BIT])
                    begin
                        state_next.fault_flag = 1'b0;
                    end
                end
                wex_pkg::IDX_DT_DUAL:
                begin
                    state_next.deadtime_low_side = wdata;
                    state_next.deadtime_high_side = wdata;
                end
                wex_pkg::IDX_DT_DUAL_BUF:
                begin
                    state_next.deadtime_low_side_buffer = wdata;
                    state_next.deadtime_high_side_buffer = wdata;
                    state_next.low_side_buffer_valid = 1'b1;
                    state_next.high_side_buffer_valid = 1'b1;
                end
                wex_pkg::IDX_DT_LOW:
                    state_next.deadtime_low_side = wdata;
                wex_pkg::IDX_DT_HIGH:
                    state_next.deadtime_high_side = wdata;
                wex_pkg::IDX_DT_LOW_BUF:
                begin
                    state_next.deadtime_low_side_buffer = wdata;
                    state_next.low_side_buffer_valid = 1'b1;
                end
                wex_pkg::IDX_DT_HIGH_BUF:
                begin
                    state_next.deadtime_high_side_buffer = wdata;
                    state_next.high_side_buffer_valid = 1'b1;
                end
                wex_pkg::IDX_OVERRIDE:
                begin
                    if (!state_reg.fault_flag)
                    begin
                        state_next.pin_override_enable = wdata;
                    end
                end
                default:
                    state_next.control = state_reg.control;
            endcase
        end

        // Flag set wins over a same-cycle clear
        if (fault_event)
        begin
            state_next.fault_flag = 1'b1;
        end

        // Fault state entry and restart
        if (fault_event)
        begin
            state_next.fault_state = 1'b1;
        end
        else if (state_reg.fault_state && timer_update && !fault_source)
        begin
            if (state_reg.fault_restart_mode == wex_pkg::MODE_CYCLE)
            begin
                state_next.fault_state = 1'b0;
            end
            else if (!state_reg.fault_flag)
            begin
                state_next.fault_state = 1'b0;
            end
        end

        // Dead-time generator results
        state_next.wave_prev = wave_sel;
        state_next.dt_count = count_next;
        state_next.dt_out = dt_next;

        // Direction clear only for the clear code, one edge after the event
        if (state_next.fault_state && (state_reg.fault_action == wex_pkg::ACT_CLEAR_DIR))
        begin
            state_next.dir_out = port_dir & ~dir_mask;
        end
        else
        begin
            state_next.dir_out = port_dir;
        end

        // Override result per pin
        state_next.pin_out = pin_next;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign pready = state_reg.pready;
    assign prdata = state_reg.prdata;
    assign pslverr = state_reg.pslverr;
    assign deadtime_out = state_reg.dt_out;
    assign dir_out = state_reg.dir_out;
    assign pin_out = state_reg.pin_out;
    assign fault_flag = state_reg.fault_flag;
    assign fault_state = state_reg.fault_state;

endmodule

/* test/timer_port_model.sv */
/*
 * Far side model: timer UPDATE strobe, lock-update flag and waveforms.
 * Assumes the bench requests UPDATE and lock by level on clk.
 */
`timescale 1ns/1ns
module timer_port_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic upd_req,
    input wire logic lock_req,
    output logic timer_update,
    output logic lock_update,
    output logic [3:0] timer_wave
);
    logic [6:0] cnt_reg;
    ////////////////////////////////////////////////////////////////
    // UPDATE and lock both follow their request levels one cycle later
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_reg <= 7'h00;
            timer_update <= 1'b0;
            lock_update <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_reg + 7'h01;
            timer_update <= upd_req;
            lock_update <= lock_req;
        end
    end
    // Channels toggle at differing rates
    assign timer_wave = cnt_reg[6:3];
endmodule

/* test/wex_checker.sv */
/*
 * Port-level assertions for the fault and dead-time block.
 * Assumes one clock, clk, and asynchronous active-low rstn.
 */
`timescale 1ns/1ns
module wex_checker (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic timer_update,
    input wire logic [7:0] port_dir,
    input wire logic [7:0] deadtime_out,
    input wire logic [7:0] dir_out,
    input wire logic fault_flag,
    input wire logic fault_state
);
    logic [1:0] age_reg;
    logic clr_w;
    assign clr_w = psel && penable && pready && pwrite && pstrb[0] && paddr == 8'h10 && pwdata[2];
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            age_reg <= 2'h0;
        else if (age_reg != 2'h3)
            age_reg <= age_reg + 2'h1;
    end
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    a_ready_after_setup: assert property (s_setup |=> s_access)
        else $error("no answer after setup");
    a_flag_clear_cause: assert property ($fell(fault_flag) |-> $past(clr_w))
        else $error("fault flag fell without a one written");
    a_flag_with_state: assert property ($rose(fault_state) |-> fault_flag)
        else $error("fault state without flag");
    a_exit_on_update: assert property ($fell(fault_state) |-> $past(timer_update))
        else $error("fault exit without update");
    a_hold_no_update: assert property (fault_state && !timer_update |=> fault_state)
        else $error("fault state left between updates");
    a_dir_follows_port: assert property (age_reg[1] && !fault_state |-> dir_out == $past(port_dir))
        else $error("direction differs from port outside fault");
    a_dir_only_cleared: assert property (age_reg[1] |-> (dir_out & ~$past(port_dir)) == 8'h00)
        else $error("direction bit set by block");
    a_dt_never_both: assert property ((deadtime_out & (deadtime_out >> 1) & 8'h55) == 8'h00)
        else $error("both sides on together");
    a_rdata_byte: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("read data above low byte");
endmodule
////////////////////////////////////////////////////////////////
bind waveform_fault_deadtime_regs wex_checker u_wex_checker (
    .clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata,
    .timer_update, .port_dir, .deadtime_out, .dir_out, .fault_flag, .fault_state
);

/* test/testbench.sv */
/*
 * Self-checking bench for the fault and dead-time register block.
 * Assumes the checker is bound and the far side model drives the timer.
 */
`timescale 1ns/1ns
module testbench;
    typedef struct { logic [3:0] idx; logic [7:0] wr; logic [7:0] exp; logic err; } row_t;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, debug_break, err;
    logic upd_req, lock_req, timer_update, lock_update, fault_flag, fault_state;
    logic [7:0] paddr, event_in, port_dir, port_out, deadtime_out, dir_out, pin_out, rd;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb, strb, timer_wave;
    int n_fail, compares;
    logic [7:0] acts [3] = '{8'h00, 8'h01, 8'h02};
    row_t rows [11] = '{'{4'h0, 8'hFF, 8'h3F, 1'b0}, '{4'h2, 8'h5A, 8'h5A, 1'b0},
        '{4'h3, 8'hFF, 8'h17, 1'b0}, '{4'h8, 8'h3C, 8'h3C, 1'b0}, '{4'h9, 8'hC3, 8'hC3, 1'b0},
        '{4'hA, 8'h11, 8'h11, 1'b0}, '{4'hB, 8'h22, 8'h22, 1'b0}, '{4'hC, 8'h81, 8'h81, 1'b0},
        '{4'h1, 8'h77, 8'h00, 1'b1}, '{4'h5, 8'h77, 8'h00, 1'b1}, '{4'hE, 8'h77, 8'h00, 1'b1}};
    waveform_fault_deadtime_regs dut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .pready, .prdata, .pslverr, .timer_update, .lock_update, .event_in, .debug_break,
        .timer_wave, .port_dir, .port_out, .deadtime_out, .dir_out, .pin_out, .fault_flag,
        .fault_state);
    timer_port_model partner (.clk, .rstn, .upd_req, .lock_req, .timer_update, .lock_update,
        .timer_wave);
    always #20 clk = ~clk;
    ////////////////////////////////////////////////////////////////
    task automatic end_sim;
        if (n_fail == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [3:0] idx, input logic [7:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        pstrb <= strb;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 16; k++)
        begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        if (k == 16)
        begin
            n_fail++;
            end_sim();
        end
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pulse_upd;
        @(posedge clk);
        upd_req <= 1'b1;
        @(posedge clk);
        upd_req <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic fault(input logic [7:0] cfg, input logic [7:0] ev);
        apb(1'b1, 4'h3, cfg);
        event_in <= ev;
        @(posedge clk);
        event_in <= 8'h00;
        repeat (2) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        rstn = 1'b0;
        {psel, penable, pwrite, debug_break, upd_req, lock_req} = 6'h00;
        {paddr, pwdata, event_in} = 48'h0;
        pstrb = 4'hF;
        strb = 4'hF;
        port_dir = 8'hFF;
        port_out = 8'hA5;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        foreach (rows[i])
        begin
            apb(1'b0, rows[i].idx, 8'h00);
            chk(rd, 8'h00);
            apb(1'b1, rows[i].idx, rows[i].wr);
            chk(8'(err), 8'(rows[i].err));
            apb(1'b0, rows[i].idx, 8'h00);
            chk(rd, rows[i].exp);
        end
        apb(1'b0, 4'h4, 8'h00);
        chk(rd, 8'h03);
        lock_req <= 1'b1;
        pulse_upd();
        apb(1'b0, 4'h8, 8'h00);
        chk(rd, 8'h3C);
        lock_req <= 1'b0;
        pulse_upd();
        apb(1'b0, 4'h8, 8'h00);
        chk(rd, 8'h11);
        apb(1'b0, 4'h9, 8'h00);
        chk(rd, 8'h22);
        apb(1'b1, 4'h7, 8'h4D);
        apb(1'b1, 4'h6, 8'h66);
        apb(1'b0, 4'h9, 8'h00);
        chk(rd, 8'h66);
        pulse_upd();
        apb(1'b0, 4'h8, 8'h00);
        chk(rd, 8'h4D);
        apb(1'b1, 4'hB, 8'h21);
        apb(1'b0, 4'h4, 8'h00);
        chk(rd, 8'h02);
        pulse_upd();
        apb(1'b0, 4'h8, 8'h00);
        chk(rd, 8'h4D);
        apb(1'b1, 4'h0, 8'h03);
        apb(1'b1, 4'h2, 8'h81);
        fault(8'h03, 8'h80);
        chk(8'(fault_flag), 8'h01);
        chk(dir_out, 8'hF0);
        apb(1'b1, 4'hC, 8'h0F);
        apb(1'b0, 4'hC, 8'h00);
        chk(rd, 8'h81);
        apb(1'b1, 4'h4, 8'h00);
        pulse_upd();
        chk(8'(fault_state), 8'h01);
        apb(1'b1, 4'h4, 8'h04);
        @(posedge clk);
        chk(8'(fault_flag), 8'h00);
        chk(8'(fault_state), 8'h01);
        pulse_upd();
        chk(dir_out, 8'hFF);
        apb(1'b1, 4'hC, 8'h0F);
        apb(1'b0, 4'hC, 8'h00);
        chk(rd, 8'h0F);
        chk(pin_out & 8'hF0, port_out & 8'hF0);
        chk(pin_out & 8'h0F, deadtime_out & 8'h0F);
        apb(1'b1, 4'h3, 8'h07);
        debug_break <= 1'b1;
        pulse_upd();
        chk(8'(fault_state), 8'h01);
        debug_break <= 1'b0;
        pulse_upd();
        chk(8'(fault_state), 8'h00);
        chk(8'(fault_flag), 8'h01);
        apb(1'b1, 4'h4, 8'h04);
        fault(8'h03, 8'h02);
        chk(8'(fault_flag), 8'h00);
        foreach (acts[i])
        begin
            fault(acts[i], 8'h01);
            chk(8'(fault_flag), 8'(acts[i] != 8'h00));
            chk(dir_out, 8'hFF);
            apb(1'b1, 4'h4, 8'h04);
            pulse_upd();
        end
        strb = 4'h0;
        apb(1'b1, 4'hC, 8'hAA);
        strb = 4'hF;
        apb(1'b0, 4'hC, 8'h00);
        chk(rd, 8'h0F);
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        apb(1'b0, 4'hC, 8'h00);
        chk(rd, 8'h00);
        end_sim();
    end
endmodule
